/* rtl/flash_host_pkg.sv */
package flash_host_pkg;
   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLK_NS        = 50;
   localparam int T_STROBE_NS   = 100;
   localparam int T_RECOVER_NS  = 50;
   localparam int T_ACCESS_NS   = 100;
   localparam int T_GAP_MAX_US  = 50;
   localparam int C_STROBE      = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int C_RECOVER     = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
   // three extra cycles cover the input synchroniser
   localparam int C_ACCESS      = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS + 3;
   localparam int C_GAP_MAX     = T_GAP_MAX_US * 1000 / CLK_NS;
   // ***************************************************
   // register map
   // ***************************************************
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_ADDR   = 8'h04;
   localparam logic [7:0] OFF_WDATA  = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_RDATA  = 8'h10;
   localparam int CTRL_BYTE_BIT  = 4;
   localparam int CTRL_HWRST_BIT = 8;
   localparam logic [8:0] CTRL_RESET = 9'h000;
   // ***************************************************
   // commands and bus cycle encodings
   // ***************************************************
   localparam logic [3:0] CMD_READ    = 4'h0;
   localparam logic [3:0] CMD_RESET   = 4'h1;
   localparam logic [3:0] CMD_AUTOSEL = 4'h2;
   localparam logic [3:0] CMD_PROG    = 4'h3;
   localparam logic [3:0] CMD_CHIP    = 4'h4;
   localparam logic [3:0] CMD_SECTOR  = 4'h5;
   localparam logic [3:0] CMD_SUSPEND = 4'h6;
   localparam logic [3:0] CMD_RESUME  = 4'h7;
   localparam logic [3:0] CMD_ADDSECT = 4'h8;
   localparam logic [15:0] D_UNLOCK1 = 16'h00AA;
   localparam logic [15:0] D_UNLOCK2 = 16'h0055;
   localparam logic [15:0] D_AUTOSEL = 16'h0090;
   localparam logic [15:0] D_PROG    = 16'h00A0;
   localparam logic [15:0] D_ESETUP  = 16'h0080;
   localparam logic [15:0] D_CHIP    = 16'h0010;
   localparam logic [15:0] D_SECTOR  = 16'h0030;
   localparam logic [15:0] D_RESUME  = 16'h0030;
   localparam logic [15:0] D_SUSPEND = 16'h00B0;
   localparam logic [15:0] D_RESET   = 16'h00F0;
   localparam logic [17:0] A_WORD1   = 18'h00555;
   localparam logic [17:0] A_WORD2   = 18'h002AA;
   localparam logic [17:0] A_BYTE1   = 18'h00AAA;
   localparam logic [17:0] A_BYTE2   = 18'h00555;
endpackage

/* rtl/flash_host.sv */
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
// Functional notes
// - suspend is one write of B0 at any address.
// - resume is one write of 30 at any address.
// - reset is one write of F0 at any address.
// - autoselect is AA, 55, 90 at unlock addresses, then a read.
// - program is two unlocks, A0, then address and data write.
// - command cycles are writes; plain array reads need no command.
// - successive command cycles are less than 50 us apart.
module flash_host
   import flash_host_pkg::*;
#(
   parameter int ADDR_W = 18
)(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   ce_n,
   output logic                   we_n,
   output logic                   oe_n,
   output logic                   flash_reset_n,
   output logic      [ADDR_W-1:0] addr_o,
   output logic      [15:0]       dq_out,
   output logic                   dq_oe_n,
   input  wire logic [15:0]       dq_in,
   input  wire logic              ready_busy_n
);
   // ***************************************************
   // types and state
   // ***************************************************
   typedef enum logic [4:0] {
      ST_IDLE    = 5'b00001,
      ST_SETUP   = 5'b00010,
      ST_STROBE  = 5'b00100,
      ST_RECOVER = 5'b01000,
      ST_READ    = 5'b10000
   } state_t;

   state_t              state_reg;
   logic [8:0]          ctrl_reg;
   logic [ADDR_W-1:0]   addr_reg;
   logic [15:0]         wdata_reg;
   logic [15:0]         rdata_reg;
   logic [3:0]          cmd_reg;
   logic                byte_reg;
   logic [2:0]          cyc_reg;
   logic [2:0]          ncyc_reg;
   logic                rd_reg;
   logic [3:0]          cnt_reg;
   logic [2:0]          rb_sync;
   logic                rb_reg;
   logic [15:0]         dq_s1;
   logic [15:0]         dq_s2;
   logic [15:0]         dq_s3;
   logic                wr_en;
   logic                mapped;
   logic                start;
   logic [2:0]          ncyc_next;
   logic [ADDR_W+15:0]  word_next;

   // ***************************************************
   // command sequence table
   // ***************************************************
   function automatic logic [ADDR_W+15:0] cyc_word(input logic [3:0] c,
      input logic [2:0] k, input logic bm, input logic [ADDR_W-1:0] a,
      input logic [15:0] d);
      logic [ADDR_W-1:0] u1;
      logic [ADDR_W-1:0] u2;
      logic [ADDR_W+15:0] w;
      u1 = bm ? ADDR_W'(A_BYTE1) : ADDR_W'(A_WORD1);
      u2 = bm ? ADDR_W'(A_BYTE2) : ADDR_W'(A_WORD2);
      w = {a, D_RESET};
      case (c)
         CMD_SUSPEND: w = {a, D_SUSPEND};
         CMD_RESUME: w = {a, D_RESUME};
         CMD_ADDSECT: w = {a, D_SECTOR};
         CMD_AUTOSEL, CMD_PROG, CMD_CHIP, CMD_SECTOR: begin
            case (k)
               3'd0: w = {u1, D_UNLOCK1};
               3'd1: w = {u2, D_UNLOCK2};
               3'd2: w = {u1, (c == CMD_AUTOSEL) ? D_AUTOSEL :
                              (c == CMD_PROG) ? D_PROG : D_ESETUP};
               3'd3: w = (c == CMD_PROG) ? {a, d} : {u1, D_UNLOCK1};
               3'd4: w = {u2, D_UNLOCK2};
               default: w = (c == CMD_CHIP) ? {u1, D_CHIP} : {a, D_SECTOR};
            endcase
         end
         default: w = {a, D_RESET};
      endcase
      return w;
   endfunction

   always_comb begin
      case (cmd_reg)
         CMD_READ: ncyc_next = 3'd0;
         CMD_AUTOSEL: ncyc_next = 3'd3;
         CMD_PROG: ncyc_next = 3'd4;
         CMD_CHIP, CMD_SECTOR: ncyc_next = 3'd6;
         default: ncyc_next = 3'd1;
      endcase
   end

   assign word_next = cyc_word(cmd_reg, cyc_reg, byte_reg, addr_reg, wdata_reg);

   // ***************************************************
   // apb slave
   // ***************************************************
   assign pready  = 1'b1;
   assign mapped  = (paddr == OFF_CTRL) || (paddr == OFF_ADDR) || (paddr == OFF_WDATA) ||
                    (paddr == OFF_STATUS) || (paddr == OFF_RDATA);
   assign pslverr = psel && penable && !mapped;
   assign wr_en   = psel && penable && pwrite;
   // a command written while busy is dropped; software polls busy first
   assign start   = wr_en && (paddr == OFF_CTRL) && (state_reg == ST_IDLE);

   always_comb begin
      case (paddr)
         OFF_CTRL: prdata = {23'h000000, ctrl_reg};
         OFF_ADDR: prdata = 32'(addr_reg);
         OFF_WDATA: prdata = {16'h0000, wdata_reg};
         OFF_STATUS: prdata = {30'h00000000, rb_reg, state_reg != ST_IDLE};
         OFF_RDATA: prdata = {16'h0000, rdata_reg};
         default: prdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg  <= CTRL_RESET;
         addr_reg  <= '0;
         wdata_reg <= 16'h0000;
      end else if (wr_en) begin
         if (paddr == OFF_ADDR) begin
            addr_reg <= pwdata[ADDR_W-1:0];
         end
         if (paddr == OFF_WDATA) begin
            wdata_reg <= pwdata[15:0];
         end
         // hardware reset bit may change at any time
         if (paddr == OFF_CTRL) begin
            ctrl_reg[CTRL_HWRST_BIT] <= pwdata[CTRL_HWRST_BIT];
            if (state_reg == ST_IDLE) begin
               ctrl_reg[CTRL_HWRST_BIT-1:0] <= pwdata[CTRL_HWRST_BIT-1:0];
            end
         end
      end
   end

   assign flash_reset_n = !ctrl_reg[CTRL_HWRST_BIT];

   // ***************************************************
   // input synchronisers
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rb_sync <= 3'b111;
         rb_reg  <= 1'b1;
         dq_s1   <= 16'h0000;
         dq_s2   <= 16'h0000;
         dq_s3   <= 16'h0000;
      end else begin
         rb_sync <= {rb_sync[1:0], ready_busy_n};
         dq_s1   <= dq_in;
         dq_s2   <= dq_s1;
         dq_s3   <= dq_s2;
         if (rb_sync[1] == rb_sync[2]) begin
            rb_reg <= rb_sync[2];
         end
      end
   end

   // ***************************************************
   // bus cycle sequencer
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         cmd_reg   <= CMD_READ;
         byte_reg  <= 1'b0;
         cyc_reg   <= 3'd0;
         ncyc_reg  <= 3'd0;
         rd_reg    <= 1'b0;
         cnt_reg   <= 4'h0;
         addr_o    <= '0;
         dq_out    <= 16'h0000;
         rdata_reg <= 16'h0000;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               cnt_reg <= 4'h0;
               cyc_reg <= 3'd0;
               if (start) begin
                  cmd_reg  <= pwdata[3:0];
                  byte_reg <= pwdata[CTRL_BYTE_BIT];
                  state_reg <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               // first pass latches the cycle count
               if (cyc_reg == 3'd0) begin
                  ncyc_reg <= ncyc_next;
                  rd_reg   <= (cmd_reg == CMD_READ) || (cmd_reg == CMD_AUTOSEL);
               end
               if (cyc_reg == 3'd0 && ncyc_next == 3'd0) begin
                  addr_o    <= addr_reg;
                  state_reg <= ST_READ;
               end else begin
                  {addr_o, dq_out} <= word_next;
                  state_reg <= ST_STROBE;
               end
            end
            ST_STROBE: begin
               cnt_reg <= cnt_reg + 4'h1;
               if (int'(cnt_reg) == C_STROBE - 1) begin
                  cnt_reg   <= 4'h0;
                  state_reg <= ST_RECOVER;
               end
            end
            ST_RECOVER: begin
               cnt_reg <= cnt_reg + 4'h1;
               if (int'(cnt_reg) == C_RECOVER - 1) begin
                  cnt_reg <= 4'h0;
                  // next cycle follows at once, far inside the gap limit
                  if (cyc_reg + 3'd1 < ncyc_reg) begin
                     cyc_reg   <= cyc_reg + 3'd1;
                     state_reg <= ST_SETUP;
                  end else if (rd_reg) begin
                     addr_o    <= addr_reg;
                     state_reg <= ST_READ;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            ST_READ: begin
               if (int'(cnt_reg) < C_ACCESS - 1) begin
                  cnt_reg <= cnt_reg + 4'h1;
               end else if (dq_s2 == dq_s3) begin
                  rdata_reg <= dq_s3;
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ***************************************************
   // pin strobes
   // ***************************************************
   assign ce_n    = !(state_reg == ST_STROBE || state_reg == ST_READ ||
                      (state_reg == ST_SETUP && cyc_reg != 3'd0));
   assign we_n    = state_reg != ST_STROBE;
   assign oe_n    = state_reg != ST_READ;
   assign dq_oe_n = state_reg != ST_STROBE;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [10:0] gap_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_cnt <= 11'h000;
      end else if (!we_n || state_reg == ST_IDLE) begin
         gap_cnt <= 11'h000;
      end else begin
         gap_cnt <= gap_cnt + 11'h001;
      end
   end

   sequence s_pulse;
      (!we_n && !ce_n && !dq_oe_n)[*2];
   endsequence
   sequence s_release;
      we_n && dq_oe_n;
   endsequence

   pulse_shape_a: assert property ($fell(we_n) |-> s_pulse ##1 s_release)
      else $error("write pulse shape wrong");
   suspend_data_a: assert property (!we_n && cmd_reg == CMD_SUSPEND |-> dq_out == D_SUSPEND)
      else $error("suspend data not B0");
   resume_data_a: assert property (!we_n && cmd_reg == CMD_RESUME |-> dq_out == D_RESUME)
      else $error("resume data not 30");
   reset_data_a: assert property (!we_n && cmd_reg == CMD_RESET |-> dq_out == D_RESET)
      else $error("reset data not F0");
   unlock_pair_a: assert property (!we_n && ncyc_reg > 3'd1 && cyc_reg < 3'd2 |->
      dq_out == (cyc_reg == 3'd0 ? D_UNLOCK1 : D_UNLOCK2))
      else $error("unlock cycle wrong");
   auto_read_a: assert property ($rose(we_n) && cmd_reg == CMD_AUTOSEL && cyc_reg == 3'd2
      |-> ##[1:4] !oe_n && addr_o == addr_reg)
      else $error("autoselect read missing");
   prog_word_a: assert property (!we_n && cmd_reg == CMD_PROG && cyc_reg == 3'd3 |->
      dq_out == wdata_reg && addr_o == addr_reg && $past(cyc_reg, 4) == 3'd2)
      else $error("program cycle wrong");
   erase_last_a: assert property (!we_n && cyc_reg == 3'd5 |-> dq_out ==
      (cmd_reg == CMD_CHIP ? D_CHIP : D_SECTOR))
      else $error("erase final cycle wrong");
   gap_limit_a: assert property (int'(gap_cnt) < C_GAP_MAX)
      else $error("command gap too long");
   read_quiet_a: assert property (!oe_n |-> we_n && dq_oe_n)
      else $error("drive during read");
endmodule

/* testbench/flash_model.sv */
`timescale 1ns/10ps
module flash_model #(
   parameter logic [15:0] MAKER = 16'h005A, // arbitrary value
   parameter logic [15:0] PART  = 16'h0A5C, // arbitrary value
   parameter int          PROT  = 3,
   parameter int          ER_US = 100
)(
   input  wire logic        ce_n,
   input  wire logic        we_n,
   input  wire logic        oe_n,
   input  wire logic        reset_n,
   input  wire logic [17:0] addr,
   input  wire logic [15:0] host_dq,
   input  wire logic        host_oe_n,
   output logic      [15:0] dq,
   output logic             ready_busy_n
);
   // ****
   // behavioural device
   // ****
   typedef enum logic [2:0] {ARRAY, AUTOSEL, PROG, WINDOW, ERASING, SUSP, CHIP} mode_t;
   mode_t       mode, back;
   int          step, left, p_left, s_left;
   logic [63:0] set;
   logic [17:0] a_lat;
   logic [15:0] mem [int];
   logic [15:0] last, rd;
   logic [7:0]  d;
   logic        u1, u2;
   wire         wr_act  = !we_n && !ce_n;
   wire         reading = !ce_n && !oe_n;
   // later fall latches address, earlier rise takes data
   always @(posedge wr_act) a_lat = addr;
   always @(negedge wr_act or negedge reset_n) begin
      d = host_dq[7:0];
      u1 = a_lat[10:0] == 11'h555 || a_lat[11:0] == 12'hAAA;
      u2 = a_lat[10:0] == 11'h2AA || a_lat[11:0] == 12'h555;
      if (!reset_n) begin
         mode = ARRAY;
         step = 0;
         set = '0;
         s_left = 0;
      end else if (mode inside {ERASING, CHIP, PROG}) begin
         if (d == 8'hB0 && mode == ERASING) s_left = 5;
      end else if (mode == WINDOW && d == 8'hB0) begin
         mode = SUSP;
         left = ER_US;
      end else if (mode == WINDOW && d == 8'h30) begin
         set[a_lat[17:12]] = 1'b1;
         left = 50;
      end else if (mode == WINDOW) begin
         mode = ARRAY;
         set = '0;
      end else if (d == 8'hF0) begin
         if (mode == AUTOSEL) mode = back;
         step = 0;
      end else if (d == 8'h30 && mode == SUSP && step == 0) mode = ERASING;
      else case (step)
         0: step = (d == 8'hAA && u1) ? 1 : 0;
         1: step = (d == 8'h55 && u2) ? 2 : 0;
         2: begin
            step = (d == 8'hA0) ? 3 : (d == 8'h80 && mode == ARRAY) ? 4 : 0;
            if (d == 8'h90 && mode != AUTOSEL) back = mode;
            if (d == 8'h90) mode = AUTOSEL;
         end
         3: begin
            mem[a_lat] = host_dq;
            back = mode;
            mode = PROG;
            p_left = 2;
            step = 0;
         end
         4: step = (d == 8'hAA && u1) ? 5 : 0;
         5: step = (d == 8'h55 && u2) ? 6 : 0;
         default: begin
            step = 0;
            if (d == 8'h10) mode = CHIP;
            if (d == 8'h10) left = ER_US;
            if (d == 8'h30) set[a_lat[17:12]] = 1'b1;
            if (d == 8'h30) mode = WINDOW;
            if (d == 8'h30) left = 50;
         end
      endcase
   end
   // one tick a microsecond; suspend during ERASING waits 5 ticks, under the 20 allowed
   initial begin
      mode = ARRAY;
      back = ARRAY;
      {step, left, p_left, s_left} = '0;
      set = '0;
      last = '0;
      forever begin
         #1000;
         if (s_left > 0 && --s_left == 0) mode = SUSP;
         if (mode == PROG && --p_left == 0) mode = back;
         if (mode inside {WINDOW, ERASING, CHIP} && --left == 0) begin
            if (mode == WINDOW) left = ER_US;
            if (mode != WINDOW) set = '0;
            mode = (mode == WINDOW) ? ERASING : ARRAY;
         end
      end
   end
   always @* begin
      if (mode == AUTOSEL)
         rd = addr[7:0] == 8'h00 ? MAKER : addr[7:0] == 8'h01 ? PART :
              {15'h0, addr[17:12] == 6'(PROT)};
      else if (mode inside {SUSP, ERASING, WINDOW} && set[addr[17:12]])
         rd = {8'h00, mode == SUSP, 7'h00};
      else rd = mem.exists(addr) ? mem[addr] : 16'hFFFF;
   end
   // released bus shows the inverse of the last value, never a held copy
   always @(rd or reading) if (reading) last = rd;
   assign dq = !host_oe_n ? host_dq : reading ? rd : ~last;
   assign ready_busy_n = !(mode inside {PROG, WINDOW, ERASING, CHIP});
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   import flash_host_pkg::*;
   // ****
   // bench
   // ****
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        ce_n, we_n, oe_n, flash_reset_n, dq_oe_n, ready_busy_n;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [17:0] addr_o;
   logic [15:0] dq_out, dq_in;
   int          fail_count, comparisons, cycles;
   flash_host i_flash_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .flash_reset_n(flash_reset_n),
      .addr_o(addr_o), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in),
      .ready_busy_n(ready_busy_n));
   flash_model i_flash_model (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .reset_n(flash_reset_n),
      .addr(addr_o), .host_dq(dq_out), .host_oe_n(dq_oe_n), .dq(dq_in),
      .ready_busy_n(ready_busy_n));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge pclk) if (++cycles == 60000) begin
      fail_count++;
      stop_test();
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cmd(input logic [3:0] c, input logic [17:0] a, input logic [15:0] d,
                      input logic [8:0] fl);
      apb(1, OFF_ADDR, {14'h0, a});
      apb(1, OFF_WDATA, {16'h0, d});
      apb(1, OFF_CTRL, {23'h0, fl | {5'h0, c}});
      do apb(0, OFF_STATUS, 0); while (rv[0] !== 1'b0);
   endtask
   task automatic rdf(input logic [17:0] a);
      cmd(CMD_READ, a, 16'h0, 9'h0);
      apb(0, OFF_RDATA, 0);
   endtask
   task automatic ry(input logic exp);
      repeat (40) @(posedge pclk);
      apb(0, OFF_STATUS, 0);
      chk("ready", {31'h0, exp}, {31'h0, rv[1]});
   endtask
   task automatic t_regs();
      apb(0, OFF_STATUS, 0);
      chk("status", 32'h2, rv);
      apb(1, 8'h40, 32'hFFFF_FFFF);
      chk("slverr", 32'h1, {31'h0, err});
      apb(0, 8'h40, 0);
      chk("unmapped", 32'h0, rv);
      apb(1, OFF_ADDR, 32'hFFFF_FFFF);
      apb(0, OFF_ADDR, 0);
      chk("addr reg", 32'h0003_FFFF, rv);
      apb(1, OFF_WDATA, 32'hFFFF_FFFF);
      apb(0, OFF_WDATA, 0);
      chk("wdata reg", 32'h0000_FFFF, rv);
   endtask
   task automatic t_prog_autosel();
      cmd(CMD_PROG, 18'h2_0010, 16'h1234, 9'h0);
      ry(1'b1);
      rdf(18'h2_0010);
      chk("array", 32'h1234, rv);
      cmd(CMD_AUTOSEL, 18'h0_0000, 16'h0, 9'h010);
      apb(0, OFF_RDATA, 0);
      chk("maker", 32'h005A, rv);
      rdf(18'h0_3002);
      chk("protected", 32'h1, rv);
      rdf(18'h0_4002);
      chk("unprotected", 32'h0, rv);
      cmd(CMD_RESET, 18'h1_F000, 16'h0, 9'h0);
      rdf(18'h2_0010);
      chk("after reset", 32'h1234, rv);
   endtask
   task automatic t_suspend();
      cmd(CMD_SECTOR, 18'h0_1000, 16'h0, 9'h0);
      ry(1'b0);
      cmd(CMD_SUSPEND, 18'h3_FFFF, 16'h0, 9'h0);
      ry(1'b1);
      rdf(18'h0_1004);
      chk("suspend status", 32'h80, rv);
      cmd(CMD_PROG, 18'h2_0020, 16'h5A5A, 9'h0);
      repeat (100) @(posedge pclk);
      rdf(18'h2_0020);
      chk("suspend prog", 32'h5A5A, rv);
      cmd(CMD_AUTOSEL, 18'h0_1001, 16'h0, 9'h0);
      apb(0, OFF_RDATA, 0);
      chk("part", 32'h0A5C, rv);
      cmd(CMD_RESET, 18'h0, 16'h0, 9'h0);
      rdf(18'h0_1004);
      chk("back to suspend", 32'h80, rv);
      cmd(CMD_RESUME, 18'h1_2345, 16'h0, 9'h0);
      cmd(CMD_RESUME, 18'h0, 16'h0, 9'h0);
      rdf(18'h0_1004);
      chk("erasing", 32'h0, rv);
      cmd(CMD_SUSPEND, 18'h0, 16'h0, 9'h0);
      // status is sampled just under 20 us after the suspend write
      repeat (340) @(posedge pclk);
      ry(1'b1);
      cmd(CMD_RESUME, 18'h0, 16'h0, 9'h0);
      repeat (2200) @(posedge pclk);
      ry(1'b1);
      rdf(18'h0_1004);
      chk("erased", 32'hFFFF, rv);
   endtask
   task automatic t_window_chip();
      cmd(CMD_SECTOR, 18'h0_5000, 16'h0, 9'h0);
      cmd(CMD_RESET, 18'h0, 16'h0, 9'h0);
      ry(1'b1);
      cmd(CMD_SECTOR, 18'h0_6000, 16'h0, 9'h0);
      cmd(CMD_ADDSECT, 18'h0_7000, 16'h0, 9'h0);
      cmd(CMD_SUSPEND, 18'h0, 16'h0, 9'h0);
      rdf(18'h0_7004);
      chk("added sector", 32'h80, rv);
      apb(1, OFF_CTRL, 32'h100);
      // the pin settles only after the edge that stores the bit
      @(posedge pclk);
      chk("reset pin", 32'h0, {31'h0, flash_reset_n});
      apb(1, OFF_CTRL, 32'h000);
      @(posedge pclk);
      chk("reset pin off", 32'h1, {31'h0, flash_reset_n});
      cmd(CMD_CHIP, 18'h0, 16'h0, 9'h010);
      cmd(CMD_SUSPEND, 18'h0, 16'h0, 9'h0);
      repeat (500) @(posedge pclk);
      ry(1'b0);
      apb(1, OFF_CTRL, 32'h100);
      apb(1, OFF_CTRL, 32'h000);
      ry(1'b1);
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      {fail_count, comparisons, cycles} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_prog_autosel();
      t_suspend();
      t_window_chip();
      stop_test();
   end
endmodule
